// *** mem_map_pkg.sv ***
// Constants shared by the bank stack and data memory map
package mem_map_pkg;

  // ----------------------------------------------------------------
  // Special function register addresses held by this block
  // ----------------------------------------------------------------
  localparam logic [7:0] SFR_STACK_PTR = 8'h81;
  localparam logic [7:0] SFR_BANK_CTRL = 8'h94;
  localparam logic [7:0] SFR_BANK_MODE = 8'h95;
  localparam logic [7:0] SFR_PAGE_R0 = 8'ha4;
  localparam logic [7:0] SFR_PAGE_R1 = 8'ha5;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_CUR_LSB = 4;
  localparam int CTRL_NEXT_LSB = 0;
  localparam int MODE_MM_BIT = 7;
  localparam int MODE_TBL_LSB = 4;
  localparam int MODE_SF_BIT = 3;
  localparam int MODE_IRQ_LSB = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] STACK_PTR_RESET = 8'h07;
  localparam logic [2:0] BANK_RESET = 3'h0;
  localparam logic [7:0] PAGE_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Sizes and address map
  // ----------------------------------------------------------------
  localparam int BANK_W = 3;
  localparam int BANK_STACK_DEPTH = 32;
  localparam logic [7:0] SFR_BASE = 8'h80;
  localparam logic [7:0] BIT_RAM_BASE = 8'h20;
  localparam logic [15:0] EXTRA_ONCHIP_RAM_BASE = 16'hf800;
  localparam int EXTRA_ONCHIP_RAM_BYTES = 2048;

  // Access kinds requested by the core
  typedef enum logic [2:0]
  {
    ACC_REG = 3'b000,
    ACC_DIRECT = 3'b001,
    ACC_INDIRECT = 3'b011,
    ACC_BIT = 3'b010,
    ACC_PUSH = 3'b110,
    ACC_POP = 3'b111
  } mem_access_e;

endpackage

// *** bank_stack.sv ***
// Hidden stack of saved current and next bank fields
`timescale 1ns/1ps
`default_nettype none
module bank_stack
#(
  parameter int DEPTH = 32,
  parameter int WIDTH = 6
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Stack operations
  input wire logic push,
  input wire logic pop,
  input wire logic [WIDTH-1:0] push_data,
  output logic [WIDTH-1:0] pop_data,
  // Status
  output logic [$clog2(DEPTH):0] level,
  output logic full
);
  localparam int LW = $clog2(DEPTH) + 1;

  logic [WIDTH-1:0] entry_reg [DEPTH];
  logic [LW-1:0] level_reg;

  initial
  begin
    if (DEPTH < 2 || WIDTH < 1)
      $error("bank_stack: DEPTH must be at least 2");
  end

  // Storage, written at the free slot
  always_ff @(posedge ref_clk)
  begin
    if (push && level_reg < LW'(DEPTH))
      entry_reg[level_reg[LW-2:0]] <= push_data;
  end

  // Pointer; push past the top is dropped
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      level_reg <= '0;
    else if (push && level_reg < LW'(DEPTH))
      level_reg <= level_reg + LW'(1);
    else if (pop && level_reg != '0)
      level_reg <= level_reg - LW'(1);
  end

  assign pop_data = (level_reg == '0) ? '0 : entry_reg[(LW-1)'(level_reg - LW'(1))];
  assign level = level_reg;
  // Warn while one slot or none is left
  assign full = level_reg >= LW'(DEPTH - 1);
endmodule
`default_nettype wire

// *** data_space_decode.sv ***
// Decode of internal data memory accesses into RAM or SPECIAL_FUNCTION_REGISTER space
`timescale 1ns/1ps
`default_nettype none
module data_space_decode
(
  // Request
  input wire mem_map_pkg::mem_access_e mode,
  input wire logic [7:0] addr,
  input wire logic [1:0] bank_sel,
  // Result
  output logic [7:0] ram_addr,
  output logic ram_sel,
  output logic sfr_sel,
  output logic [2:0] bit_pos
);
  import mem_map_pkg::*;

  function automatic logic [7:0] reg_addr(input logic [1:0] bank, input logic [2:0] idx);
    reg_addr = {3'b000, bank, idx};
  endfunction

  function automatic logic [7:0] bit_byte(input logic [7:0] a);
    if (a[7])
      bit_byte = {a[7:3], 3'b000};
    else
      bit_byte = BIT_RAM_BASE + {4'h0, a[6:3]};
  endfunction

  always_comb
  begin
    ram_addr = addr;
    ram_sel = 1'b0;
    sfr_sel = 1'b0;
    bit_pos = addr[2:0];
    case (mode)
      ACC_REG:
      begin
        ram_addr = reg_addr(bank_sel, addr[2:0]);
        ram_sel = 1'b1;
      end
      ACC_DIRECT:
      begin
        sfr_sel = addr[7];
        ram_sel = !addr[7];
      end
      ACC_BIT:
      begin
        ram_addr = bit_byte(addr);
        sfr_sel = addr[7];
        ram_sel = !addr[7];
      end
      default:
      begin
        ram_sel = 1'b1;
      end
    endcase
  end
endmodule
`default_nettype wire

// *** bank_memory_map.sv ***
// Program bank control and internal data memory map
//
// How it works
// - Bank stack: 32 entries of six bits
// - Call pushes banks, next becomes current
// - Return pops banks back to earlier values
// - Interrupt pushes, then loads interrupt bank into current and next
// - Reset clears mode, table and interrupt banks
// - Read-only warning when bank stack nearly full
// - Four data blocks; upper RAM/SPECIAL_FUNCTION_REGISTER split by mode
// - Bytes 0-31 hold four PROGRAM_STATUS_WORD-selected register banks
// - Bit addresses map onto bytes 32 to 47
// - Upper RAM by indirect and stack access, SFRs by direct and bit access
// - Main stack: reloadable 8-bit pointer, any RAM
// - Extra RAM via DPTR moves from F800
// - Ri moves take high byte from page register
// - SFRs occupy direct addresses 128 to 255
// - SPECIAL_FUNCTION_REGISTER bit access only at multiples of eight
// - Long jump copies next bank into current
// - Table reads use table bank when mode set
`timescale 1ns/1ps
`default_nettype none
module bank_memory_map
#(
  parameter int EXTRA_ONCHIP_RAM_SIZE = 2048
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Sequencer events, one cycle each; table_read is a level
  input wire logic call_evt,
  input wire logic ret_evt,
  input wire logic irq_evt,
  input wire logic ljmp_evt,
  input wire logic table_read,
  // Program address bits 16 to 18
  output logic [2:0] prog_bank_addr,
  // Internal data memory port
  input wire logic mem_req,
  input wire mem_map_pkg::mem_access_e mem_mode,
  input wire logic [7:0] mem_addr,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  input wire logic [1:0] bank_sel,
  output logic [7:0] mem_rdata,
  output logic sfr_ext,
  // External move port
  input wire logic movx_req,
  input wire logic movx_use_ri,
  input wire logic movx_ri_sel,
  input wire logic [15:0] dptr,
  input wire logic [7:0] ri_value,
  input wire logic movx_wr,
  input wire logic [7:0] movx_wdata,
  output logic [15:0] movx_addr,
  output logic extra_onchip_ram_hit,
  output logic [7:0] movx_rdata
);
  import mem_map_pkg::*;

  localparam int XA = $clog2(EXTRA_ONCHIP_RAM_SIZE);
  localparam int SL = $clog2(BANK_STACK_DEPTH) + 1;

  initial
  begin
    if (EXTRA_ONCHIP_RAM_SIZE != 1024 && EXTRA_ONCHIP_RAM_SIZE != 2048)
      $error("bank_memory_map: EXTRA_ONCHIP_RAM_SIZE must be 1024 or 2048");
  end

  logic [2:0] cur_bank_reg;
  logic [2:0] next_bank_reg;
  logic [2:0] irq_bank_reg;
  logic [2:0] tbl_bank_reg;
  logic mm_reg;
  logic [7:0] page_r0_reg;
  logic [7:0] page_r1_reg;
  logic [7:0] sp_reg;
  logic [7:0] ram_reg [256];
  logic [7:0] extra_onchip_ram_reg [EXTRA_ONCHIP_RAM_SIZE];
  logic [5:0] stk_pop_data;
  logic [SL-1:0] stk_level;
  logic stack_full;
  logic stk_push;
  logic stk_pop;
  logic [7:0] eff_addr;
  logic [7:0] dec_ram_addr;
  logic dec_ram_sel;
  logic dec_sfr_sel;
  logic [2:0] dec_bit_pos;
  logic sfr_we;
  logic ram_byte_we;
  logic ram_bit_we;
  logic [16:0] extra_onchip_ram_off;

  // ----------------------------------------------------------------
  // SPECIAL_FUNCTION_REGISTER helpers
  // ----------------------------------------------------------------
  function automatic logic own_sfr(input logic [7:0] a);
    own_sfr = (a == SFR_STACK_PTR) || (a == SFR_BANK_CTRL) || (a == SFR_BANK_MODE)
      || (a == SFR_PAGE_R0) || (a == SFR_PAGE_R1);
  endfunction

  function automatic logic [7:0] sfr_read(input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      SFR_STACK_PTR: v = sp_reg;
      SFR_BANK_CTRL:
      begin
        v[CTRL_CUR_LSB +: BANK_W] = cur_bank_reg;
        v[CTRL_NEXT_LSB +: BANK_W] = next_bank_reg;
      end
      SFR_BANK_MODE:
      begin
        v[MODE_MM_BIT] = mm_reg;
        v[MODE_TBL_LSB +: BANK_W] = tbl_bank_reg;
        v[MODE_SF_BIT] = stack_full;
        v[MODE_IRQ_LSB +: BANK_W] = irq_bank_reg;
      end
      SFR_PAGE_R0: v = page_r0_reg;
      SFR_PAGE_R1: v = page_r1_reg;
      default: v = 8'h00;
    endcase
    sfr_read = v;
  endfunction

  // ----------------------------------------------------------------
  // Address decode and bank stack
  // ----------------------------------------------------------------
  always_comb
  begin
    case (mem_mode)
      ACC_PUSH: eff_addr = sp_reg + 8'h01;
      ACC_POP: eff_addr = sp_reg;
      default: eff_addr = mem_addr;
    endcase
  end

  data_space_decode u_decode
  (
    .mode(mem_mode),
    .addr(eff_addr),
    .bank_sel(bank_sel),
    .ram_addr(dec_ram_addr),
    .ram_sel(dec_ram_sel),
    .sfr_sel(dec_sfr_sel),
    .bit_pos(dec_bit_pos)
  );

  assign stk_push = irq_evt || call_evt;
  assign stk_pop = !stk_push && ret_evt;

  bank_stack #(.DEPTH(BANK_STACK_DEPTH), .WIDTH(2 * BANK_W)) u_stack
  (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .push(stk_push),
    .pop(stk_pop),
    .push_data({cur_bank_reg, next_bank_reg}),
    .pop_data(stk_pop_data),
    .level(stk_level),
    .full(stack_full)
  );

  assign sfr_we = mem_req && mem_wr && mem_mode == ACC_DIRECT && dec_sfr_sel;
  // Bit access names the byte that holds the bit, not the bit address
  assign sfr_ext = mem_req && dec_sfr_sel && !own_sfr(dec_ram_addr);

  // ----------------------------------------------------------------
  // Program banking
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cur_bank_reg <= BANK_RESET;
      next_bank_reg <= BANK_RESET;
    end
    else if (irq_evt)
    begin
      cur_bank_reg <= irq_bank_reg;
      next_bank_reg <= irq_bank_reg;
    end
    else if (call_evt)
      cur_bank_reg <= next_bank_reg;
    else if (ret_evt)
    begin
      if (stk_level != '0)
        {cur_bank_reg, next_bank_reg} <= stk_pop_data;
    end
    else if (ljmp_evt)
      cur_bank_reg <= next_bank_reg;
    else if (sfr_we && eff_addr == SFR_BANK_CTRL)
      next_bank_reg <= mem_wdata[CTRL_NEXT_LSB +: BANK_W];
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mm_reg <= 1'b0;
      tbl_bank_reg <= BANK_RESET;
      irq_bank_reg <= BANK_RESET;
    end
    else if (sfr_we && eff_addr == SFR_BANK_MODE)
    begin
      mm_reg <= mem_wdata[MODE_MM_BIT];
      tbl_bank_reg <= mem_wdata[MODE_TBL_LSB +: BANK_W];
      irq_bank_reg <= mem_wdata[MODE_IRQ_LSB +: BANK_W];
    end
  end

  assign prog_bank_addr = (table_read && mm_reg) ? tbl_bank_reg : cur_bank_reg;

  // ----------------------------------------------------------------
  // Page registers and main stack pointer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      page_r0_reg <= PAGE_RESET;
      page_r1_reg <= PAGE_RESET;
    end
    else if (sfr_we && eff_addr == SFR_PAGE_R0)
      page_r0_reg <= mem_wdata;
    else if (sfr_we && eff_addr == SFR_PAGE_R1)
      page_r1_reg <= mem_wdata;
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      sp_reg <= STACK_PTR_RESET;
    else if (mem_req && mem_mode == ACC_PUSH)
      sp_reg <= sp_reg + 8'h01;
    else if (mem_req && mem_mode == ACC_POP)
      sp_reg <= sp_reg - 8'h01;
    else if (sfr_we && eff_addr == SFR_STACK_PTR)
      sp_reg <= mem_wdata;
  end

  // ----------------------------------------------------------------
  // Internal data RAM
  // ----------------------------------------------------------------
  assign ram_byte_we = mem_req && dec_ram_sel
    && (mem_mode == ACC_PUSH || (mem_wr && mem_mode != ACC_POP && mem_mode != ACC_BIT));
  assign ram_bit_we = mem_req && mem_wr && mem_mode == ACC_BIT && dec_ram_sel;

  always_ff @(posedge ref_clk)
  begin
    if (ram_byte_we)
      ram_reg[dec_ram_addr] <= mem_wdata;
    else if (ram_bit_we)
      ram_reg[dec_ram_addr][dec_bit_pos] <= mem_wdata[0];
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      mem_rdata <= 8'h00;
    else if (mem_req && !mem_wr && mem_mode != ACC_PUSH)
    begin
      if (mem_mode == ACC_BIT)
        mem_rdata <= {7'h00, dec_ram_sel && ram_reg[dec_ram_addr][dec_bit_pos]};
      else if (dec_sfr_sel)
        mem_rdata <= sfr_read(eff_addr);
      else
        mem_rdata <= ram_reg[dec_ram_addr];
    end
  end

  // ----------------------------------------------------------------
  // External moves and extra on-chip RAM
  // ----------------------------------------------------------------
  assign extra_onchip_ram_off = {1'b0, dptr} - {1'b0, EXTRA_ONCHIP_RAM_BASE};
  assign extra_onchip_ram_hit = movx_req && !movx_use_ri && !extra_onchip_ram_off[16]
    && extra_onchip_ram_off < 17'(EXTRA_ONCHIP_RAM_SIZE);
  assign movx_addr = movx_use_ri ? {(movx_ri_sel ? page_r1_reg : page_r0_reg), ri_value}
    : dptr;

  always_ff @(posedge ref_clk)
  begin
    if (extra_onchip_ram_hit && movx_wr)
      extra_onchip_ram_reg[extra_onchip_ram_off[XA-1:0]] <= movx_wdata;
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      movx_rdata <= 8'h00;
    else if (extra_onchip_ram_hit && !movx_wr)
      movx_rdata <= extra_onchip_ram_reg[extra_onchip_ram_off[XA-1:0]];
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking main_clk @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_call_then_ret;
    (call_evt && !irq_evt && !stack_full) ##1 (ret_evt && !irq_evt && !call_evt);
  endsequence

  sequence s_irq_then_fetch;
    irq_evt ##1 !table_read;
  endsequence

  AST_CALL_LOADS_NEXT: assert property ((call_evt && !irq_evt) |=> cur_bank_reg == $past(next_bank_reg))
    else $error("Call did not load next bank");
  AST_RET_RESTORES: assert property (s_call_then_ret |=> {cur_bank_reg, next_bank_reg} ==
    $past({cur_bank_reg, next_bank_reg}, 2))
    else $error("Return did not restore banks");
  AST_IRQ_BANKS: assert property (irq_evt |=> cur_bank_reg == $past(irq_bank_reg)
    && next_bank_reg == $past(irq_bank_reg))
    else $error("Interrupt bank not loaded");
  AST_RESET_CLEARS: assert property ($past(sys_rst) |-> !mm_reg && tbl_bank_reg == 3'h0 && irq_bank_reg == 3'h0)
    else $error("Mode fields not cleared by reset");
  AST_FULL_WARN: assert property ((call_evt && stk_level == SL'(BANK_STACK_DEPTH - 2)) |=> stack_full)
    else $error("Stack full warning missing");
  AST_REG_BANK: assert property ((mem_req && mem_mode == ACC_REG) |-> dec_ram_addr ==
    {3'b000, bank_sel, mem_addr[2:0]})
    else $error("Register bank address wrong");
  AST_BIT_RAM: assert property ((mem_req && mem_mode == ACC_BIT && !mem_addr[7]) |-> dec_ram_sel
    && dec_ram_addr == 8'h20 + {4'h0, mem_addr[6:3]})
    else $error("Bit byte address wrong");
  AST_NO_INDIRECT_SFR: assert property ((mem_req && mem_mode == ACC_INDIRECT) |-> !dec_sfr_sel && !sfr_ext)
    else $error("Indirect access reached SPECIAL_FUNCTION_REGISTER space");
  AST_PUSH_SP: assert property ((mem_req && mem_mode == ACC_PUSH) |=> sp_reg == $past(sp_reg) + 8'h01)
    else $error("Push did not advance stack pointer");
  AST_EXTRA_ONCHIP_RAM_LOW: assert property ((movx_req && dptr < EXTRA_ONCHIP_RAM_BASE) |-> !extra_onchip_ram_hit)
    else $error("Extra RAM hit below its base");
  AST_PAGE_ADDR: assert property ((movx_req && movx_use_ri) |-> movx_addr[15:8] ==
    (movx_ri_sel ? page_r1_reg : page_r0_reg))
    else $error("Page register not on high address");
  AST_LJMP: assert property ((ljmp_evt && !irq_evt && !call_evt && !ret_evt) |=> cur_bank_reg == $past(next_bank_reg))
    else $error("Long jump did not switch bank");
  AST_TABLE_BANK: assert property (table_read |-> prog_bank_addr == (mm_reg ? tbl_bank_reg : cur_bank_reg))
    else $error("Table read bank wrong");
  AST_IRQ_FETCH: assert property (s_irq_then_fetch |-> prog_bank_addr == $past(irq_bank_reg))
    else $error("Service fetch not in interrupt bank");
endmodule
`default_nettype wire

// *** core_seq_model.sv ***
// Sequencer model that issues bank events to the memory map
`timescale 1ns/1ps
`default_nettype none
module core_seq_model
(
  // Clock
  input wire logic ref_clk,
  // Events towards the bank logic
  output logic call_evt,
  output logic ret_evt,
  output logic irq_evt,
  output logic ljmp_evt,
  output logic table_read
);
  initial
  begin
    {call_evt, ret_evt, irq_evt, ljmp_evt, table_read} = 5'h00;
  end

  // ------------------------------------------------------------
  // One-cycle event: 0 call, 1 return, 2 interrupt, 3 long jump
  // ------------------------------------------------------------
  task automatic fire(input int kind);
    @(negedge ref_clk);
    case (kind)
      0: call_evt = 1'b1;
      1: ret_evt = 1'b1;
      2: irq_evt = 1'b1;
      default: ljmp_evt = 1'b1;
    endcase
    @(negedge ref_clk);
    {call_evt, ret_evt, irq_evt, ljmp_evt} = 4'h0;
  endtask

  // Call and return on consecutive edges
  task automatic call_ret();
    @(negedge ref_clk);
    call_evt = 1'b1;
    @(negedge ref_clk);
    call_evt = 1'b0;
    ret_evt = 1'b1;
    @(negedge ref_clk);
    ret_evt = 1'b0;
  endtask

  // Table read level, changed off the sampling edge
  task automatic tbl(input logic v);
    @(negedge ref_clk);
    table_read = v;
  endtask
endmodule
`default_nettype wire

// *** bank_memory_map_tb_top.sv ***
// Testbench for the bank stack and data memory map
`timescale 1ns/1ps
`default_nettype none
module bank_memory_map_tb_top;
  import mem_map_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic call_evt, ret_evt, irq_evt, ljmp_evt, table_read, ext, extra_onchip_ram_hit, sfr_ext;
  logic mem_req, mem_wr, movx_req, movx_use_ri, movx_ri_sel, movx_wr;
  mem_access_e mem_mode;
  logic [7:0] mem_addr, mem_wdata, mem_rdata, ri_value, movx_wdata, movx_rdata, rd;
  logic [1:0] bank_sel;
  logic [2:0] prog_bank_addr;
  logic [15:0] dptr, movx_addr, ma;
  int n_fail = 0;
  int total_checks = 0;
  int cycles = 0;

  always #12.5 ref_clk = ~ref_clk;

  core_seq_model seq_u (.ref_clk(ref_clk), .call_evt(call_evt), .ret_evt(ret_evt), .irq_evt(irq_evt),
    .ljmp_evt(ljmp_evt), .table_read(table_read));

  bank_memory_map dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .call_evt(call_evt), .ret_evt(ret_evt),
    .irq_evt(irq_evt), .ljmp_evt(ljmp_evt), .table_read(table_read), .prog_bank_addr(prog_bank_addr),
    .mem_req(mem_req), .mem_mode(mem_mode), .mem_addr(mem_addr), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
    .bank_sel(bank_sel), .mem_rdata(mem_rdata), .sfr_ext(sfr_ext), .movx_req(movx_req),
    .movx_use_ri(movx_use_ri), .movx_ri_sel(movx_ri_sel), .dptr(dptr), .ri_value(ri_value),
    .movx_wr(movx_wr), .movx_wdata(movx_wdata), .movx_addr(movx_addr), .extra_onchip_ram_hit(extra_onchip_ram_hit),
    .movx_rdata(movx_rdata));

  // ------------------------------------------------------------
  // Access tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic acc(input mem_access_e m, input logic [7:0] a, input logic w, input logic [7:0] d);
    @(negedge ref_clk);
    mem_req = 1'b1;
    mem_mode = m;
    mem_addr = a;
    mem_wr = w;
    mem_wdata = d;
    #1 ext = sfr_ext;
    @(negedge ref_clk);
    mem_req = 1'b0;
    mem_wr = 1'b0;
    rd = mem_rdata;
  endtask

  task automatic rdc(input mem_access_e m, input logic [7:0] a, input logic [7:0] e);
    acc(m, a, 1'b0, 8'h00);
    chk(16'(rd), 16'(e));
  endtask

  task automatic mvx(input logic ri, input logic s, input logic [15:0] p, input logic w, input logic [7:0] d);
    @(negedge ref_clk);
    movx_req = 1'b1;
    movx_use_ri = ri;
    movx_ri_sel = s;
    dptr = p;
    ri_value = p[7:0];
    movx_wr = w;
    movx_wdata = d;
    #1 ext = extra_onchip_ram_hit;
    ma = movx_addr;
    @(negedge ref_clk);
    movx_req = 1'b0;
    movx_wr = 1'b0;
    rd = movx_rdata;
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Hang guard
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_fail++;
      results();
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    {mem_req, mem_wr, movx_req, movx_use_ri, movx_ri_sel, movx_wr} = 6'h00;
    mem_mode = ACC_REG;
    {mem_addr, mem_wdata, ri_value, movx_wdata} = 32'h0;
    bank_sel = 2'h0;
    dptr = 16'h0000;
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    sys_rst = 1'b0;
    rdc(ACC_DIRECT, SFR_BANK_MODE, 8'h00);
    rdc(ACC_DIRECT, SFR_BANK_CTRL, 8'h00);
    rdc(ACC_DIRECT, SFR_STACK_PTR, STACK_PTR_RESET);
    // Nested calls and returns
    acc(ACC_DIRECT, SFR_BANK_CTRL, 1'b1, 8'hfb);
    rdc(ACC_DIRECT, SFR_BANK_CTRL, 8'h03);
    seq_u.fire(0);
    chk(16'(prog_bank_addr), 16'h3);
    acc(ACC_DIRECT, SFR_BANK_CTRL, 1'b1, 8'h05);
    seq_u.fire(0);
    chk(16'(prog_bank_addr), 16'h5);
    seq_u.fire(1);
    rdc(ACC_DIRECT, SFR_BANK_CTRL, 8'h35);
    chk(16'(prog_bank_addr), 16'h3);
    seq_u.fire(1);
    rdc(ACC_DIRECT, SFR_BANK_CTRL, 8'h03);
    // Interrupt bank, then long jump
    acc(ACC_DIRECT, SFR_BANK_MODE, 1'b1, 8'h06);
    seq_u.fire(2);
    chk(16'(prog_bank_addr), 16'h6);
    rdc(ACC_DIRECT, SFR_BANK_CTRL, 8'h66);
    seq_u.fire(1);
    rdc(ACC_DIRECT, SFR_BANK_CTRL, 8'h03);
    seq_u.fire(3);
    chk(16'(prog_bank_addr), 16'h3);
    // Return right behind a call
    acc(ACC_DIRECT, SFR_BANK_CTRL, 1'b1, 8'h05);
    seq_u.call_ret();
    rdc(ACC_DIRECT, SFR_BANK_CTRL, 8'h35);
    // Table read bank select
    acc(ACC_DIRECT, SFR_BANK_MODE, 1'b1, 8'hc6);
    seq_u.tbl(1'b1);
    #1 chk(16'(prog_bank_addr), 16'h4);
    acc(ACC_DIRECT, SFR_BANK_MODE, 1'b1, 8'h46);
    chk(16'(prog_bank_addr), 16'h3);
    seq_u.tbl(1'b0);
    // Fill all 32 bank stack entries
    for (int i = 0; i < 32; i++)
    begin
      acc(ACC_DIRECT, SFR_BANK_CTRL, 1'b1, 8'(i % 8));
      seq_u.fire(0);
      rdc(ACC_DIRECT, SFR_BANK_MODE, (i >= 30) ? 8'h4e : 8'h46);
    end
    seq_u.fire(1);
    rdc(ACC_DIRECT, SFR_BANK_CTRL, 8'h67);
    repeat (31) seq_u.fire(1);
    rdc(ACC_DIRECT, SFR_BANK_CTRL, 8'h30);
    // Register banks and bit area
    bank_sel = 2'h2;
    acc(ACC_REG, 8'h05, 1'b1, 8'ha5);
    rdc(ACC_DIRECT, 8'h15, 8'ha5);
    acc(ACC_DIRECT, 8'h21, 1'b1, 8'h00);
    acc(ACC_BIT, 8'h09, 1'b1, 8'h01);
    rdc(ACC_DIRECT, 8'h21, 8'h02);
    acc(ACC_DIRECT, 8'h2f, 1'b1, 8'h00);
    acc(ACC_BIT, 8'h7f, 1'b1, 8'h01);
    rdc(ACC_DIRECT, 8'h2f, 8'h80);
    // Upper RAM against SPECIAL_FUNCTION_REGISTER space
    acc(ACC_INDIRECT, 8'h90, 1'b1, 8'h3c);
    rdc(ACC_INDIRECT, 8'h90, 8'h3c);
    acc(ACC_DIRECT, 8'h90, 1'b0, 8'h00);
    chk(16'(ext), 16'h1);
    acc(ACC_DIRECT, 8'h40, 1'b1, 8'h77);
    chk(16'(ext), 16'h0);
    rdc(ACC_INDIRECT, 8'h40, 8'h77);
    acc(ACC_INDIRECT, 8'h81, 1'b1, 8'hee);
    rdc(ACC_DIRECT, 8'h81, STACK_PTR_RESET);
    rdc(ACC_INDIRECT, 8'h81, 8'hee);
    acc(ACC_BIT, 8'ha5, 1'b1, 8'h01);
    chk(16'(ext), 16'h1);
    rdc(ACC_DIRECT, SFR_PAGE_R1, PAGE_RESET);
    // Main stack push and pop
    acc(ACC_DIRECT, SFR_STACK_PTR, 1'b1, 8'h40);
    acc(ACC_PUSH, 8'h00, 1'b1, 8'h5a);
    rdc(ACC_DIRECT, SFR_STACK_PTR, 8'h41);
    rdc(ACC_INDIRECT, 8'h41, 8'h5a);
    rdc(ACC_POP, 8'h00, 8'h5a);
    rdc(ACC_DIRECT, SFR_STACK_PTR, 8'h40);
    // External moves
    acc(ACC_DIRECT, SFR_PAGE_R0, 1'b1, 8'h12);
    acc(ACC_DIRECT, SFR_PAGE_R1, 1'b1, 8'hab);
    mvx(1'b0, 1'b0, 16'hf800, 1'b1, 8'h99);
    chk(16'(ext), 16'h1);
    mvx(1'b0, 1'b0, 16'hf800, 1'b0, 8'h00);
    chk(16'(rd), 16'h99);
    mvx(1'b0, 1'b0, 16'hf7ff, 1'b0, 8'h00);
    chk(16'(ext), 16'h0);
    mvx(1'b0, 1'b0, 16'hffff, 1'b0, 8'h00);
    chk(16'(ext), 16'h1);
    mvx(1'b1, 1'b0, 16'h0034, 1'b0, 8'h00);
    chk(ma, 16'h1234);
    mvx(1'b1, 1'b1, 16'h0034, 1'b0, 8'h00);
    chk(ma, 16'hab34);
    // Mid-run reset clears the mode fields again
    acc(ACC_DIRECT, SFR_BANK_MODE, 1'b1, 8'hf7);
    rdc(ACC_DIRECT, SFR_BANK_MODE, 8'hf7);
    @(negedge ref_clk);
    sys_rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    sys_rst = 1'b0;
    rdc(ACC_DIRECT, SFR_BANK_MODE, 8'h00);
    rdc(ACC_DIRECT, SFR_BANK_CTRL, 8'h00);
    results();
  end
endmodule
`default_nettype wire
